// file: rtl/umb_map.vh
// Purpose: Register map, field codes and constants of the UART block
// Assumes: APB byte addresses, word aligned, 32-bit data
// Notes: Definitions only
`ifndef UMB_MAP_VH
`define UMB_MAP_VH
`define UMB_A_TXBUF 5'h00
`define UMB_A_RXBUF 5'h04
`define UMB_A_FRAME 5'h08
`define UMB_A_MODE 5'h0C
`define UMB_A_STAT 5'h10
`define UMB_A_ICTRL 5'h14
`define UMB_A_PRESC 5'h18
`define UMB_A_DIV 5'h1C
`define UMB_CHR_7 2'h0
`define UMB_CHR_8 2'h1
`define UMB_LEN_7 4'h7
`define UMB_LEN_8 4'h8
`define UMB_LEN_9 4'h9
`define UMB_PSC_OFF 5'h00
`define UMB_OVERSAMPLE 5'h10
`define UMB_RX_MID 4'h7
`define UMB_FRAME_IDLE 12'hFFF
`define UMB_FRAME_RST 6'h00
`define UMB_MODE_RST 3'h0
`define UMB_ICTRL_RST 4'h0
`define UMB_DIV_RST 11'h000
`endif

// file: rtl/umb_uart.v
// Purpose: UART core with attention, loopback, 7/8/9-bit frames, baud generator, interrupts
// Assumes: Inputs synchronous to ref_clk; APB slave with zero wait states
// Notes: Oversample fixed at sixteen; one start bit
// Functional notes
// (R1) Attention mode needs 9-bit, no parity
// (R2) Ninth bit one marks address, zero data
// (R3) Wait bit set discards non-address characters
// (R4) Address stored, full set, wait cleared
// (R5) Software re-arms wait bit after address
// (R6) Transmitter unchanged; ninth bit from control
// (R7) Received ninth bit readable in status
// (R8) Loopback feeds transmit into receiver internally
// (R9) Loopback uses 9-bit, no parity
// (R10) Seven-bit frame, optional parity, 1-2 stops
// (R11) Eight-bit frame, optional parity, 1-2 stops
// (R12) Nine-bit frame never carries parity
// (R13) Five-bit prescaler then eleven-bit divisor
// (R14) Prescaler factor is (code+1)/2
// (R15) Prescaler code zero stops UART clock
// (R16) Stop clock before changing baud rate
// (R17) Baud = clock/(16*(divisor+1)*factor)
// (R18) Tx irq = empty and enable
// (R19) Rx irq = full and enable
// (R20) Error irq; status read clears error
// (R21) Flow irq; control read clears change
// (R22) Raw RXD and CTS go to wakeup
// (R23) Sixteen sample ticks per bit
// (R24) Complete character sets full; read clears
// (R25) Frame end loads buffer, sets empty
// (R26) Half factors alternate division lengths
// (R27) Interrupts combinational from flag registers
//
// Design decisions made here: the address map and register access over APB.
`timescale 1ns/1ns
`include "umb_map.vh"
module umb_uart #(
	parameter DIV_W = 11
) (
	input wire ref_clk,
	input wire rst_n,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [4:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire rxd,
	output wire txd,
	input wire ctsN,
	output wire txIrq,
	output wire rxIrq,
	output wire flowIrq,
	output wire wakeRxd,
	output wire wakeCtsN
);
	function [3:0] dataLen;
		input [1:0] chr;
		input forced9;
		begin
			if (forced9)
				dataLen = `UMB_LEN_9;
			else if (chr == `UMB_CHR_7)
				dataLen = `UMB_LEN_7;
			else if (chr == `UMB_CHR_8)
				dataLen = `UMB_LEN_8;
			// Codes two and three both select nine bits
			else
				dataLen = `UMB_LEN_9;
		end
	endfunction

	function parityOf;
		input [8:0] d;
		input [3:0] dl;
		input odd;
		integer i;
		reg p;
		begin
			p = odd;
			for (i = 0; i < 9; i = i + 1)
				if (i < dl)
					p = p ^ d[i];
			parityOf = p;
		end
	endfunction

	reg [7:0] txBuf_ff;
	reg [7:0] rxBuf_ff;
	reg [5:0] frame_ff;
	reg [2:0] mode_ff;
	reg [3:0] ictrl_ff;
	reg [4:0] presc_ff;
	reg [DIV_W-1:0] div_ff;
	reg txEmpty_ff, rxFull_ff, rxNinth_ff, rxErr_ff, ctsChg_ff, ctsPrev_ff;
	reg [5:0] pscAcc_ff;
	reg [DIV_W-1:0] divCnt_ff;
	reg txBusy_ff;
	reg [11:0] txSh_ff;
	reg [3:0] txLeft_ff;
	reg [3:0] txSub_ff;
	reg txd_ff;
	reg rxBusy_ff, rxStart_ff;
	reg [3:0] rxSub_ff;
	reg [3:0] rxIdx_ff;
	reg [9:0] rxSh_ff;

	wire [1:0] chrSel = frame_ff[1:0];
	wire twoStop = frame_ff[2];
	wire txNinth = frame_ff[3];
	wire parEn = frame_ff[4];
	wire parOdd = frame_ff[5];
	wire attnEn = mode_ff[0];
	wire attnWait = mode_ff[1];
	wire diag = mode_ff[2];
	// Special modes force 9-bit, which also removes parity
	wire [3:0] dl = dataLen(chrSel, attnEn | diag); // [R1] [R9]
	wire parUse = parEn & (dl != `UMB_LEN_9); // [R10] [R11] [R12]

	// APB access
	wire setup = psel & ~penable;
	wire access = psel & penable;
	wire wr = access & pwrite;
	wire rd = access & ~pwrite;
	wire mapped = (paddr[1:0] == 2'h0);
	assign pready = access;
	// Misaligned access only flags an error; no register sees it
	assign pslverr = access & ~mapped;
	wire wrTx = wr & mapped & (paddr == `UMB_A_TXBUF);
	wire rdRx = rd & (paddr == `UMB_A_RXBUF);
	wire rdStat = rd & (paddr == `UMB_A_STAT);
	wire rdIctrl = rd & (paddr == `UMB_A_ICTRL);

	// Latched in setup so read data stands through the access cycle
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			prdata <= 32'h00000000;
		end else if (setup) begin
			case (paddr)
			`UMB_A_TXBUF: prdata <= {24'h000000, txBuf_ff};
			`UMB_A_RXBUF: prdata <= {24'h000000, rxBuf_ff};
			`UMB_A_FRAME: prdata <= {26'h0000000, frame_ff};
			`UMB_A_MODE: prdata <= {29'h00000000, mode_ff};
			`UMB_A_STAT: prdata <= {27'h0000000, ctsChg_ff, rxErr_ff, rxNinth_ff, rxFull_ff,
				txEmpty_ff}; // [R7]
			`UMB_A_ICTRL: prdata <= {27'h0000000, ctsChg_ff, ictrl_ff};
			`UMB_A_PRESC: prdata <= {27'h0000000, presc_ff};
			`UMB_A_DIV: prdata <= {{(32-DIV_W){1'b0}}, div_ff};
			default: prdata <= 32'h00000000;
			endcase
		end
	end

	// Baud generator: prescaler accumulates half-cycles so x.5 factors
	// alternate between two lengths one cycle apart
	wire pscOff = (presc_ff == `UMB_PSC_OFF);
	wire [5:0] pscNeed = {1'b0, presc_ff} + 6'h01;
	wire [5:0] pscNext = pscAcc_ff + 6'h02;
	wire pscTick = ~pscOff & (pscNext >= pscNeed); // [R14] [R26]
	wire smpTick = pscTick & (divCnt_ff == div_ff); // [R13] [R17]

	always @(posedge ref_clk) begin
		if (!rst_n || pscOff) begin
			pscAcc_ff <= 6'h00; // [R15]
			divCnt_ff <= {DIV_W{1'b0}};
		end else begin
			pscAcc_ff <= pscTick ? pscNext - pscNeed : pscNext; // [R26]
			if (pscTick)
				divCnt_ff <= smpTick ? {DIV_W{1'b0}} : divCnt_ff + 1'b1; // [R17]
		end
	end

	// Control registers and flags
	wire txLoad;
	wire rxDone;
	wire rxStore;
	wire rxAddr;
	wire rxBad;
	wire [8:0] rxWord;
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			txBuf_ff <= 8'h00;
			frame_ff <= `UMB_FRAME_RST;
			mode_ff <= `UMB_MODE_RST;
			ictrl_ff <= `UMB_ICTRL_RST;
			presc_ff <= `UMB_PSC_OFF;
			div_ff <= `UMB_DIV_RST;
			txEmpty_ff <= 1'b1;
			rxFull_ff <= 1'b0;
			rxNinth_ff <= 1'b0;
			rxBuf_ff <= 8'h00;
			rxErr_ff <= 1'b0;
			ctsChg_ff <= 1'b0;
			// Track the pin through reset so release shows no false change
			ctsPrev_ff <= ctsN;
		end else begin
			if (wr && paddr == `UMB_A_FRAME)
				frame_ff <= pwdata[5:0];
			if (wr && paddr == `UMB_A_ICTRL)
				ictrl_ff <= pwdata[3:0];
			if (wr && paddr == `UMB_A_PRESC)
				presc_ff <= pwdata[4:0];
			if (wr && paddr == `UMB_A_DIV)
				div_ff <= pwdata[DIV_W-1:0];
			// Hardware clear of the wait bit wins over a same-cycle write
			if (rxStore && rxAddr && attnEn && attnWait)
				mode_ff[1] <= 1'b0; // [R4]
			else if (wr && paddr == `UMB_A_MODE)
				mode_ff <= pwdata[2:0]; // [R5]
			if (wr && paddr == `UMB_A_MODE)
				{mode_ff[2], mode_ff[0]} <= {pwdata[2], pwdata[0]};
			if (wrTx)
				txBuf_ff <= pwdata[7:0];
			// A write in the load cycle brings fresh data, so it leaves empty clear
			if (wrTx)
				txEmpty_ff <= 1'b0; // [R18]
			else if (txLoad)
				txEmpty_ff <= 1'b1; // [R25]
			if (rxStore) begin
				rxBuf_ff <= rxWord[7:0]; // [R24]
				rxNinth_ff <= rxWord[8]; // [R7]
				rxFull_ff <= 1'b1; // [R4] [R24]
			end else if (rdRx) begin
				rxFull_ff <= 1'b0; // [R19] [R24]
			end
			if (rxBad)
				rxErr_ff <= 1'b1;
			else if (rdStat)
				rxErr_ff <= 1'b0; // [R20]
			ctsPrev_ff <= ctsN;
			if (ctsN != ctsPrev_ff)
				ctsChg_ff <= 1'b1;
			else if (rdIctrl)
				ctsChg_ff <= 1'b0; // [R21]
		end
	end

	// Transmitter; ninth bit always from the control bit, whatever the mode
	wire [8:0] txWord = {txNinth, txBuf_ff}; // [R6] [R12]
	wire [3:0] txLen = 4'h1 + dl + {3'h0, parUse} + (twoStop ? 4'h2 : 4'h1); // [R10] [R11]
	reg [11:0] txFrame;
	integer k;
	always @* begin
		// All-ones default supplies the stop bits
		txFrame = `UMB_FRAME_IDLE;
		txFrame[0] = 1'b0;
		for (k = 0; k < 9; k = k + 1)
			if (k < dl)
				txFrame[k+1] = txWord[k];
		if (parUse)
			txFrame[dl+4'h1] = parityOf(txWord, dl, parOdd); // [R10] [R11]
	end
	// CTS stops a new frame from starting, never one in flight
	assign txLoad = ~txBusy_ff & ~txEmpty_ff & ~ctsN & ~pscOff; // [R25]
	wire txBitEnd = smpTick & (txSub_ff == `UMB_OVERSAMPLE - 5'h01); // [R23]

	always @(posedge ref_clk) begin
		if (!rst_n) begin
			txBusy_ff <= 1'b0;
			txSh_ff <= `UMB_FRAME_IDLE;
			txLeft_ff <= 4'h0;
			txSub_ff <= 4'h0;
			txd_ff <= 1'b1;
		end else begin
			if (txLoad) begin
				txBusy_ff <= 1'b1;
				txSh_ff <= txFrame;
				txLeft_ff <= txLen;
				txSub_ff <= 4'h0;
			end else if (txBusy_ff && smpTick) begin
				txSub_ff <= txSub_ff + 4'h1;
				if (txBitEnd) begin
					txSh_ff <= {1'b1, txSh_ff[11:1]};
					txLeft_ff <= txLeft_ff - 4'h1;
					if (txLeft_ff == 4'h1)
						txBusy_ff <= 1'b0;
				end
			end
			txd_ff <= txBusy_ff ? txSh_ff[0] : 1'b1;
		end
	end
	// Pin idles high in loopback so the peer sees nothing
	assign txd = diag ? 1'b1 : txd_ff;

	// Receiver
	wire rxLine = diag ? txd_ff : rxd; // [R8]
	wire rxMid = smpTick & (rxSub_ff == `UMB_RX_MID);
	wire [3:0] rxBody = dl + {3'h0, parUse};
	wire rxFinal = rxBusy_ff & ~rxStart_ff & rxMid & (rxIdx_ff == rxBody);
	assign rxDone = rxFinal;
	// Bits beyond the data length read zero in short formats
	assign rxWord = {(dl == `UMB_LEN_9) & rxSh_ff[8],
		(dl != `UMB_LEN_7) & rxSh_ff[7], rxSh_ff[6:0]};
	assign rxAddr = rxWord[8]; // [R2]
	// Non-address characters are dropped while waiting
	wire rxDrop = attnEn & attnWait & ~rxAddr; // [R3]
	assign rxStore = rxDone & ~rxDrop; // [R4] [R24]
	wire parErr = parUse & (rxSh_ff[dl] != parityOf(rxSh_ff[8:0], dl, parOdd)); // [R12]
	// Parity, framing or overrun; the character is still stored
	assign rxBad = rxStore & (parErr | ~rxLine | rxFull_ff);

	always @(posedge ref_clk) begin
		if (!rst_n) begin
			rxBusy_ff <= 1'b0;
			rxStart_ff <= 1'b0;
			rxSub_ff <= 4'h0;
			rxIdx_ff <= 4'h0;
			rxSh_ff <= 10'h000;
		end else if (smpTick) begin
			if (!rxBusy_ff) begin
				if (!rxLine) begin
					rxBusy_ff <= 1'b1;
					rxStart_ff <= 1'b1;
					rxSub_ff <= 4'h1;
					rxIdx_ff <= 4'h0;
				end
			end else begin
				rxSub_ff <= rxSub_ff + 4'h1; // [R23]
				if (rxMid) begin
					if (rxStart_ff) begin
						rxStart_ff <= 1'b0;
						// Glitch shorter than half a bit is not a start
						if (rxLine)
							rxBusy_ff <= 1'b0;
					end else if (rxIdx_ff == rxBody) begin
						rxBusy_ff <= 1'b0;
					end else begin
						rxSh_ff[rxIdx_ff] <= rxLine; // [R8]
						rxIdx_ff <= rxIdx_ff + 4'h1;
					end
				end
			end
		end
	end

	// Interrupts straight from registered flags and enables
	assign txIrq = txEmpty_ff & ictrl_ff[0]; // [R18] [R27]
	assign rxIrq = (rxFull_ff & ictrl_ff[1]) | (rxErr_ff & ictrl_ff[2]); // [R19] [R20] [R27]
	assign flowIrq = ctsChg_ff & ictrl_ff[3]; // [R21] [R27]
	// Raw pins, so wakeup sees edges even with the clock stopped
	assign wakeRxd = rxd; // [R22]
	assign wakeCtsN = ctsN; // [R22]
endmodule // umb_uart

// file: sim/umb_uart_monitor.sv
// Purpose: Port-level checks of the UART block
// Assumes: Single clock domain, synchronous active-low reset
// Notes: Bound to umb_uart below
`timescale 1ns/1ns
`include "umb_map.vh"
module umb_uart_monitor (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [4:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic rxd,
	input wire logic txd,
	input wire logic ctsN,
	input wire logic txIrq,
	input wire logic rxIrq,
	input wire logic flowIrq,
	input wire logic wakeRxd,
	input wire logic wakeCtsN
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	wire acc = psel && penable;
	// Shortest bit is sixteen ticks of one clock
	sequence s_low8;
		!txd [*8];
	endsequence
	sequence s_high8;
		txd [*8];
	endsequence
	a_bit_low: assert property ($fell(txd) |-> s_low8)
		else $error("txd low run too short");
	a_bit_high: assert property ($rose(txd) |-> s_high8)
		else $error("txd high run too short");
	a_wake_rxd: assert property (wakeRxd == rxd)
		else $error("wake rxd copy differs");
	a_wake_cts: assert property (wakeCtsN == ctsN)
		else $error("wake cts copy differs");
	a_tx_clear: assert property (acc && pwrite && paddr == `UMB_A_TXBUF |=> !txIrq)
		else $error("tx irq stays after buffer write");
	a_irq_rst: assert property ($rose(rst_n) |-> !txIrq && !rxIrq && !flowIrq)
		else $error("irq active after reset");
	a_flow_clear: assert property (acc && !pwrite && paddr == `UMB_A_ICTRL
		&& $stable(ctsN) |=> !flowIrq)
		else $error("flow irq stays after control read");
	a_irq_off: assert property (acc && pwrite && paddr == `UMB_A_ICTRL
		&& pwdata[3:0] == 4'h0 |=> !txIrq && !rxIrq && !flowIrq)
		else $error("irq stays with enables cleared");
endmodule // umb_uart_monitor
bind umb_uart umb_uart_monitor mon_u (.ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr,
	.pwdata, .rxd, .txd, .ctsN, .txIrq, .rxIrq, .flowIrq, .wakeRxd, .wakeCtsN);

// file: sim/umb_peer.sv
// Purpose: Far-end serial device model
// Assumes: Bit time of BIT clocks on the receive side
// Notes: Line idles at mark level between frames
`timescale 1ns/1ns
module umb_peer #(
	parameter int BIT = 16
) (
	input wire logic refClk,
	input wire logic txd,
	output logic rxd,
	output logic ctsN
);
	initial begin
		rxd = 1'b1;
		ctsN = 1'b0;
	end
	// Start, data, ninth or parity, stop; LSB first
	task automatic send(input logic [10:0] f);
		for (int i = 0; i < 11; i++) begin
			@(posedge refClk);
			rxd <= f[i];
			repeat (BIT - 1) @(posedge refClk);
		end
	endtask
	task automatic setCts(input logic v);
		@(posedge refClk);
		ctsN <= v;
	endtask
	// Length of the first high run after a start bit; the start bit
	// itself may be short, since it begins off the tick phase
	task automatic bitLen(output int n);
		n = 0;
		for (int t = 0; t < 20000 && txd; t++) @(posedge refClk);
		for (int t = 0; t < 5000 && !txd; t++) @(posedge refClk);
		while (txd && n < 5000) begin
			n++;
			@(posedge refClk);
		end
	endtask
endmodule // umb_peer

// file: sim/test_uart_modes_baud_irq.sv
// Purpose: Self-checking bench of the UART block
// Assumes: APB master tasks, peer model on the serial side
// Notes: Fast baud setting keeps frames at 16 clocks a bit
`timescale 1ns/1ns
`include "umb_map.vh"
module test_uart_modes_baud_irq;
	logic refClk, rstN, psel, penable, pwrite;
	logic [4:0] paddr;
	logic [31:0] pwdata, rd;
	wire [31:0] prdata;
	wire pready, pslverr, rxd, txd, ctsN, txIrq, rxIrq, flowIrq;
	int n_mismatch, total_checks, k, n;
	int ps [4] = '{1, 2, 3, 31};
	int dv [4] = '{0, 0, 1, 0};
	int bl [4] = '{16, 24, 64, 256};
	umb_uart dut_u (.ref_clk(refClk), .rst_n(rstN), .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .rxd, .txd, .ctsN, .txIrq, .rxIrq,
		.flowIrq, .wakeRxd(), .wakeCtsN());
	umb_peer peerU (.refClk(refClk), .txd(txd), .rxd(rxd), .ctsN(ctsN));
	initial begin
		refClk = 1'b0;
		forever #50 refClk = ~refClk;
	end
	task automatic complete_run;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [4:0] a, input logic [31:0] d);
		int t;
		@(posedge refClk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge refClk);
		penable <= 1'b1;
		t = 0;
		do begin
			@(posedge refClk);
			t++;
		end while (pready !== 1'b1 && t < 20);
		chk(pready, 1);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1)
			complete_run();
		// Flags launched at the access edge settle before callers look
		@(negedge refClk);
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rdc(input logic [4:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd, e);
	endtask
	initial begin
		repeat (60000) @(posedge refClk);
		n_mismatch++;
		complete_run();
	end
	initial begin
		{psel, penable, pwrite, paddr, pwdata, rstN} = '0;
		repeat (8) @(posedge refClk);
		rstN <= 1'b1;
		rdc(`UMB_A_STAT, 32'h1);
		rdc(`UMB_A_PRESC, 32'h0);
		for (k = 0; k < 4; k++) begin
			wr(`UMB_A_PRESC, 32'h0);
			wr(`UMB_A_DIV, dv[k]);
			wr(`UMB_A_FRAME, 32'h1);
			wr(`UMB_A_PRESC, ps[k]);
			wr(`UMB_A_TXBUF, 32'h1);
			peerU.bitLen(n);
			chk(n, bl[k]);
			repeat (bl[k] * 10) @(posedge refClk);
		end
		$display("baud test done");
		wr(`UMB_A_PRESC, 32'h0);
		wr(`UMB_A_PRESC, 32'h1);
		wr(`UMB_A_FRAME, 32'h2);
		wr(`UMB_A_ICTRL, 32'h2);
		peerU.send({2'b11, 8'hA5, 1'b0});
		rdc(`UMB_A_STAT, 32'h7);
		chk(rxIrq, 1);
		rdc(`UMB_A_RXBUF, 32'hA5);
		chk(rxIrq, 0);
		$display("ninth bit test done");
		wr(`UMB_A_MODE, 32'h3);
		peerU.send({2'b10, 8'h5A, 1'b0});
		// Ninth bit of the last stored character stays
		rdc(`UMB_A_STAT, 32'h5);
		peerU.send({2'b11, 8'h42, 1'b0});
		rdc(`UMB_A_MODE, 32'h1);
		rdc(`UMB_A_RXBUF, 32'h42);
		peerU.send({2'b10, 8'h17, 1'b0});
		rdc(`UMB_A_RXBUF, 32'h17);
		$display("attention test done");
		wr(`UMB_A_MODE, 32'h0);
		wr(`UMB_A_FRAME, 32'h11);
		wr(`UMB_A_ICTRL, 32'h4);
		peerU.send({2'b11, 8'h03, 1'b0});
		chk(rxIrq, 1);
		rdc(`UMB_A_STAT, 32'hB);
		chk(rxIrq, 0);
		rdc(`UMB_A_RXBUF, 32'h03);
		wr(`UMB_A_FRAME, 32'h34);
		peerU.send({2'b11, 1'b0, 7'h2A, 1'b0});
		rdc(`UMB_A_STAT, 32'h3);
		rdc(`UMB_A_RXBUF, 32'h2A);
		$display("error test done");
		wr(`UMB_A_ICTRL, 32'h8);
		peerU.setCts(1'b1);
		repeat (4) @(posedge refClk);
		chk(flowIrq, 1);
		rdc(`UMB_A_ICTRL, 32'h18);
		chk(flowIrq, 0);
		wr(`UMB_A_ICTRL, 32'h1);
		chk(txIrq, 1);
		wr(`UMB_A_TXBUF, 32'h55);
		chk(txIrq, 0);
		peerU.setCts(1'b0);
		repeat (4) @(posedge refClk);
		chk(txIrq, 1);
		wr(`UMB_A_ICTRL, 32'h0);
		chk(txIrq, 0);
		repeat (200) @(posedge refClk);
		$display("irq test done");
		wr(`UMB_A_MODE, 32'h4);
		wr(`UMB_A_TXBUF, 32'h3C);
		repeat (250) @(posedge refClk);
		chk(txd, 1);
		rdc(`UMB_A_RXBUF, 32'h3C);
		$display("loopback test done");
		complete_run();
	end
endmodule // test_uart_modes_baud_irq
